/* File: cbs_buf_if.sv */
// Carrier between the state control and its command/response byte store.
// Assumes both ends run on the same clock; all strobes are one cycle wide.
`timescale 1ns/1ps
interface cbs_buf_if;
	logic wr_en;
	logic [cbs_pkg::BUF_AW-1:0] wr_addr;
	logic [7:0] wr_data;
	logic clear;
	logic rd_en;
	logic [cbs_pkg::BUF_AW-1:0] rd_addr;
	logic [7:0] rd_data;
	logic rd_valid;
	logic [cbs_pkg::BUF_CW-1:0] count;

	modport ctrl (
		output wr_en, wr_addr, wr_data, clear, rd_en, rd_addr,
		input rd_data, rd_valid, count
	);
	modport store (
		input wr_en, wr_addr, wr_data, clear, rd_en, rd_addr,
		output rd_data, rd_valid, count
	);
endinterface

/* File: cbs_buffer.sv */
// Byte store for commands and responses, with base-restart access order.
// Assumes the control side gates every access by interface state.
`timescale 1ns/1ps
module cbs_buffer (
	// Clock and reset
	input logic clock,
	input logic rstn,
	// Control side
	cbs_buf_if.store bus
);
	logic [7:0] mem [cbs_pkg::BUF_DEPTH];
	logic [cbs_pkg::BUF_AW-1:0] rd_next;
	logic wr_take;
	logic rd_take;

	// Only the base or the next sequential byte is accepted.
	assign wr_take = bus.wr_en && (bus.wr_addr == cbs_pkg::BUF_BASE ||
		({1'b0, bus.wr_addr} == bus.count));
	assign rd_take = bus.rd_en && (bus.rd_addr == cbs_pkg::BUF_BASE ||
		(bus.rd_addr == rd_next && {1'b0, bus.rd_addr} < bus.count));

	always_ff @(posedge clock) begin
		if (wr_take) begin
			mem[bus.wr_addr] <= bus.wr_data;
		end
	end

	// ****************************************
	// Fill level
	// ****************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bus.count <= cbs_pkg::COUNT_RESET;
		end else if (bus.clear) begin
			bus.count <= cbs_pkg::COUNT_RESET;
		end else if (wr_take && bus.wr_addr == cbs_pkg::BUF_BASE) begin
			bus.count <= cbs_pkg::BUF_CW'(1);
		end else if (wr_take) begin
			bus.count <= bus.count + 1'b1;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_next <= cbs_pkg::BUF_BASE;
			bus.rd_data <= 8'h00;
			bus.rd_valid <= 1'b0;
		end else begin
			bus.rd_valid <= rd_take;
			if (rd_take) begin
				bus.rd_data <= mem[bus.rd_addr];
				rd_next <= bus.rd_addr + 1'b1;
			end
		end
	end
endmodule // cbs_buffer

/* File: cbs_ctrl.sv */
// State control of the command/response buffer interface.
// Assumes host strobes come from logic on the same clock, a locality is
// already held, and command processing reports its end on exec_done.
`timescale 1ns/1ps

// Functional notes
// - Finished command may briefly show with start still set.
// - Behaviour holds only with a fixed, already selected locality.
// - After initialisation enter Idle: idle flag 1, other fields 0.
// - Idle plus ready request goes to Ready, idle flag cleared.
// - Idle plus idle request stays in Idle.
// - Idle ignores start; flags unchanged.
// - Idle ignores cancel; stays in Idle.
// - Idle ignores every buffer read and write.
// - Ready ignores another ready request.
// - Ready plus idle request resets interface to Idle.
// - Buffer write in Ready enters Reception; more writes keep it.
// - Ready with empty buffer ignores start; start reads 0.
// - Ready ignores cancel.
// - Ready ignores buffer reads.
// - Reception plus start goes to Execution with start reading 1.
// - Reception ignores cancel and buffer reads.
// - Reception plus ready request returns to Ready, dropping command.
// - Start is given by writing 0001h; writes of 0 are ignored.
// - End of processing clears start and enters Completion.
// - Base-address write invalidates and replaces earlier contents.
module cbs_ctrl (
	// Clock and reset
	input logic clock,
	input logic rstn,
	// Request field write
	input logic req_wr,
	input logic req_ready_data,
	input logic req_idle_data,
	// Start and cancel field writes
	input logic start_wr,
	input logic [31:0] start_data,
	input logic cancel_wr,
	input logic [31:0] cancel_data,
	// Buffer access
	input logic buf_wr,
	input logic [cbs_pkg::BUF_AW-1:0] buf_wr_addr,
	input logic [7:0] buf_wr_data,
	input logic buf_rd,
	input logic [cbs_pkg::BUF_AW-1:0] buf_rd_addr,
	output logic [7:0] buf_rd_data,
	output logic buf_rd_valid,
	// Command processing
	input logic exec_done,
	output logic exec_start,
	output logic [cbs_pkg::BUF_CW-1:0] cmd_length,
	// Visible fields
	output logic ready_request_bit,
	output logic idle_request_bit,
	output logic idle_flag,
	output logic status_fault_flag,
	output logic [31:0] start_field,
	output logic [31:0] cancel_field,
	output cbs_pkg::cbs_state_type state
);

	// ****************************************
	// Declarations
	// ****************************************
	cbs_pkg::cbs_state_type next_state;
	logic init_done;
	logic start_go;
	logic cancel_go;
	logic enter_exec;
	logic leave_exec;
	logic buf_clear;
	logic buf_wr_ok;
	logic buf_rd_ok;

	cbs_buf_if buf_link ();

	// Only the exact go value counts; any other value, zero included,
	// leaves the field alone.
	function automatic logic is_go(input logic [31:0] value);
		is_go = (value == cbs_pkg::FIELD_GO);
	endfunction

	// ****************************************
	// Sub-blocks
	// ****************************************
	cbs_init_timer u_init (
		.clock(clock),
		.rstn(rstn),
		.done(init_done)
	);

	cbs_buffer u_buffer (
		.clock(clock),
		.rstn(rstn),
		.bus(buf_link)
	);

	// ****************************************
	// Write decoding
	// ****************************************
	// Go value only
	assign start_go = start_wr && is_go(start_data);
	assign cancel_go = cancel_wr && is_go(cancel_data);

	// ****************************************
	// Request bits
	// ****************************************
	// A request is held for one cycle, or until Init ends, so the host can see it, then the
	// state logic consumes it. A new write in the consuming cycle wins.
	// Self clearing requests
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ready_request_bit <= cbs_pkg::REQUEST_RESET;
		end else if (req_wr && req_ready_data) begin
			ready_request_bit <= 1'b1;
		end else if (state != cbs_pkg::CBS_INIT) begin
			ready_request_bit <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			idle_request_bit <= cbs_pkg::REQUEST_RESET;
		end else if (req_wr && req_idle_data) begin
			idle_request_bit <= 1'b1;
		end else if (state != cbs_pkg::CBS_INIT) begin
			idle_request_bit <= 1'b0;
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	// Single locality
	always_comb begin
		next_state = state;
		case (state)
			cbs_pkg::CBS_INIT: begin
				if (init_done) begin
					next_state = cbs_pkg::CBS_IDLE;
				end
			end
			cbs_pkg::CBS_IDLE: begin
				if (ready_request_bit && !idle_request_bit) begin
					next_state = cbs_pkg::CBS_READY;
				end
			end
			cbs_pkg::CBS_READY: begin
				if (idle_request_bit) begin
					next_state = cbs_pkg::CBS_IDLE;
				end else if (buf_wr) begin
					next_state = cbs_pkg::CBS_RECEPTION;
				end
			end
			cbs_pkg::CBS_RECEPTION: begin
				if (idle_request_bit) begin
					next_state = cbs_pkg::CBS_IDLE;
				end else if (ready_request_bit) begin
					next_state = cbs_pkg::CBS_READY;
				end else if (start_go) begin
					next_state = cbs_pkg::CBS_EXECUTION;
				end
			end
			cbs_pkg::CBS_EXECUTION: begin
				if (exec_done) begin
					next_state = cbs_pkg::CBS_COMPLETION;
				end
			end
			cbs_pkg::CBS_COMPLETION: begin
				// The response stays until the host sends the device idle.
				if (idle_request_bit) begin
					next_state = cbs_pkg::CBS_IDLE;
				end
			end
			default: begin
				next_state = cbs_pkg::CBS_INIT;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= cbs_pkg::CBS_INIT;
		end else begin
			state <= next_state;
		end
	end

	assign enter_exec = (state == cbs_pkg::CBS_RECEPTION) &&
		(next_state == cbs_pkg::CBS_EXECUTION);
	assign leave_exec = (state == cbs_pkg::CBS_EXECUTION) && exec_done;

	// ****************************************
	// Status flags
	// ****************************************
	// Idle flag tracks Idle
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			idle_flag <= cbs_pkg::IDLE_FLAG_RESET;
		end else begin
			idle_flag <= (next_state == cbs_pkg::CBS_IDLE);
		end
	end

	// No transition handled here reports a fault; the flag is kept as a
	// register so a later fault source only needs a set term.
	// Fault stays clear
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			status_fault_flag <= cbs_pkg::FAULT_RESET;
		end else begin
			status_fault_flag <= cbs_pkg::FAULT_RESET;
		end
	end

	// ****************************************
	// Start field
	// ****************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			start_field <= cbs_pkg::START_RESET;
		end else if (enter_exec) begin
			start_field <= cbs_pkg::FIELD_GO;
		end else if (leave_exec) begin
			start_field <= cbs_pkg::FIELD_CLEAR;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			exec_start <= 1'b0;
		end else begin
			exec_start <= enter_exec;
		end
	end

	// ****************************************
	// Cancel field
	// ****************************************
	// Cancel only has meaning during execution; elsewhere it reads 0.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cancel_field <= cbs_pkg::CANCEL_RESET;
		end else if (leave_exec) begin
			cancel_field <= cbs_pkg::FIELD_CLEAR;
		end else if (cancel_go && state == cbs_pkg::CBS_EXECUTION) begin
			cancel_field <= cbs_pkg::FIELD_GO;
		end
	end

	// ****************************************
	// Buffer gating
	// ****************************************
	// Entering Idle from any state, or leaving Reception for Ready, drops the contents.
	// Discard partial command
	assign buf_clear = ((state != cbs_pkg::CBS_IDLE) &&
		(next_state == cbs_pkg::CBS_IDLE)) ||
		((state == cbs_pkg::CBS_RECEPTION) &&
		(next_state == cbs_pkg::CBS_READY));

	assign buf_wr_ok = buf_wr && !buf_clear &&
		(next_state == cbs_pkg::CBS_RECEPTION);

	// Reads before completion have no response to return.
	// Ready read dropped
	assign buf_rd_ok = buf_rd && (state == cbs_pkg::CBS_COMPLETION);

	assign buf_link.wr_en = buf_wr_ok;
	assign buf_link.wr_addr = buf_wr_addr;
	assign buf_link.wr_data = buf_wr_data;
	assign buf_link.clear = buf_clear;
	assign buf_link.rd_en = buf_rd_ok;
	assign buf_link.rd_addr = buf_rd_addr;

	assign buf_rd_data = buf_link.rd_data;
	assign buf_rd_valid = buf_link.rd_valid;
	assign cmd_length = buf_link.count;

endmodule // cbs_ctrl

/* File: cbs_ctrl_properties.sv */
// Port-level checks of the command buffer state control.
// Assumes a single clock domain; bound to every instance of the control.
`timescale 1ns/1ps
module cbs_ctrl_properties (
	// Clock and reset
	input logic clock,
	input logic rstn,
	// Host accesses
	input logic req_wr,
	input logic req_ready_data,
	input logic req_idle_data,
	input logic start_wr,
	input logic [31:0] start_data,
	input logic cancel_wr,
	input logic buf_wr,
	input logic [cbs_pkg::BUF_AW-1:0] buf_wr_addr,
	input logic buf_rd,
	input logic exec_done,
	// Visible fields
	input logic buf_rd_valid,
	input logic exec_start,
	input logic [cbs_pkg::BUF_CW-1:0] cmd_length,
	input logic ready_request_bit,
	input logic idle_request_bit,
	input logic idle_flag,
	input logic status_fault_flag,
	input logic [31:0] start_field,
	input logic [31:0] cancel_field,
	input cbs_pkg::cbs_state_type state
);
	localparam cbs_pkg::cbs_state_type IDL = cbs_pkg::CBS_IDLE;
	localparam cbs_pkg::cbs_state_type RDY = cbs_pkg::CBS_READY;
	localparam cbs_pkg::cbs_state_type RCV = cbs_pkg::CBS_RECEPTION;
	localparam cbs_pkg::cbs_state_type EXE = cbs_pkg::CBS_EXECUTION;
	logic pend;
	assign pend = ready_request_bit || idle_request_bit;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// A lone ready request, with a quiet cycle after it.
	sequence lone_ready(s);
		state == s && req_wr && req_ready_data && !req_idle_data && !buf_wr
		##1 !req_wr && !buf_wr;
	endsequence
	idle_match_a: assert property (idle_flag == (state == IDL))
		else $error("idle flag disagrees with state");
	fault_low_a: assert property (status_fault_flag == 1'h0)
		else $error("fault flag set");
	ready_go_a: assert property (lone_ready(IDL) |-> ready_request_bit
		##1 state == RDY && !idle_flag && !ready_request_bit)
		else $error("idle did not move to ready");
	idle_back_a: assert property (
		state == RDY && req_wr && req_idle_data |-> ##2 state == IDL)
		else $error("idle request in ready not taken");
	idle_stay_a: assert property (
		state == IDL && !ready_request_bit && !(req_wr && req_ready_data)
		|=> state == IDL && start_field == cbs_pkg::FIELD_CLEAR
		&& cancel_field == cbs_pkg::FIELD_CLEAR)
		else $error("idle left or fields changed");
	rx_enter_a: assert property (
		state == RDY && buf_wr && buf_wr_addr == cbs_pkg::BUF_BASE && !pend
		|=> state == RCV && cmd_length == 7'h01)
		else $error("buffer write in ready not taken");
	start_go_a: assert property (
		state == RCV && start_wr && start_data == cbs_pkg::FIELD_GO && !pend
		|=> state == EXE && start_field == cbs_pkg::FIELD_GO && exec_start)
		else $error("start in reception not taken");
	start_ign_a: assert property (
		start_wr && !pend && !buf_wr && (state == RDY
		|| state == RCV && start_data != cbs_pkg::FIELD_GO)
		|=> state == $past(state) && start_field == cbs_pkg::FIELD_CLEAR)
		else $error("start write not ignored");
	cancel_ign_a: assert property (
		cancel_wr && !pend && !buf_wr && !start_wr
		&& (state == RDY || state == RCV)
		|=> state == $past(state) && cancel_field == cbs_pkg::FIELD_CLEAR)
		else $error("cancel write not ignored");
	read_ign_a: assert property (
		buf_rd && (state == RDY || state == RCV) |=> !buf_rd_valid)
		else $error("buffer read answered too early");
	done_clear_a: assert property (
		state == EXE && exec_done |=> state == cbs_pkg::CBS_COMPLETION
		&& start_field == cbs_pkg::FIELD_CLEAR)
		else $error("done did not clear start");
endmodule // cbs_ctrl_properties

bind cbs_ctrl cbs_ctrl_properties cbs_ctrl_properties_inst (.clock, .rstn,
	.req_wr, .req_ready_data, .req_idle_data, .start_wr, .start_data,
	.cancel_wr, .buf_wr, .buf_wr_addr, .buf_rd, .exec_done, .buf_rd_valid,
	.exec_start, .cmd_length, .ready_request_bit, .idle_request_bit,
	.idle_flag, .status_fault_flag, .start_field, .cancel_field, .state);

/* File: cbs_init_timer.sv */
// Settle timer that marks the end of initialisation after reset release.
// Assumes rstn is already synchronised to clock.
`timescale 1ns/1ps
module cbs_init_timer (
	// Clock and reset
	input logic clock,
	input logic rstn,
	// Status
	output logic done
);
	logic [cbs_pkg::INIT_CW-1:0] count;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count <= '0;
			done <= 1'b0;
		end else if (!done) begin
			count <= count + 1'b1;
			done <= (count == cbs_pkg::INIT_CW'(cbs_pkg::INIT_CYCLES - 1));
		end
	end
endmodule // cbs_init_timer

/* File: cbs_pkg.sv */
// Package of shared constants and types for the command buffer state control.
// Assumes a single 200 MHz clock domain and host strobes on that clock.
package cbs_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLOCK_PERIOD_NS = 5;
	// Longest settle time from reset release to Idle, kept under the timeout.
	localparam int INIT_DELAY_NS = 100;
	localparam int INIT_CYCLES = (INIT_DELAY_NS / CLOCK_PERIOD_NS < 1) ? 1 :
		INIT_DELAY_NS / CLOCK_PERIOD_NS;
	localparam int INIT_CW = 8;

	// ****************************************
	// Field values
	// ****************************************
	localparam logic [31:0] FIELD_GO = 32'h0000_0001;
	localparam logic [31:0] FIELD_CLEAR = 32'h0000_0000;
	localparam logic [31:0] START_RESET = 32'h0000_0000;
	localparam logic [31:0] CANCEL_RESET = 32'h0000_0000;
	localparam logic REQUEST_RESET = 1'h0;
	localparam logic IDLE_FLAG_RESET = 1'h0;
	localparam logic FAULT_RESET = 1'h0;

	// ****************************************
	// Buffer geometry
	// ****************************************
	localparam int BUF_DEPTH = 64;
	localparam int BUF_AW = 6;
	localparam int BUF_CW = 7;
	localparam logic [BUF_AW-1:0] BUF_BASE = 6'h00;
	localparam logic [BUF_CW-1:0] COUNT_RESET = 7'h00;

	// ****************************************
	// Interface states
	// ****************************************
	typedef enum logic [2:0] {
		CBS_INIT,
		CBS_IDLE,
		CBS_READY,
		CBS_RECEPTION,
		CBS_EXECUTION,
		CBS_COMPLETION
	} cbs_state_type;

endpackage

/* File: cbs_proc_model.sv */
// Stand-in for command processing: answers each start with a done pulse.
// Assumes exec_start is a one-cycle pulse on the shared clock.
`timescale 1ns/1ps
module cbs_proc_model #(
	parameter int DELAY = 6
) (
	// Clock and reset
	input logic clock,
	input logic rstn,
	// Processing handshake
	input logic exec_start,
	output logic exec_done
);
	int count;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count <= 0;
			exec_done <= 1'h0;
		end else begin
			exec_done <= (count == 1);
			if (exec_start)
				count <= DELAY;
			else if (count != 0)
				count <= count - 1;
		end
	end
endmodule // cbs_proc_model

/* File: test_command_buffer_state_ctrl.sv */
// Self-checking bench of the command buffer state control.
// Assumes the processing stand-in and the shared package constants.
`timescale 1ns/1ps
module test_command_buffer_state_ctrl;
	logic clock = 1'h0;
	logic rstn = 1'h0;
	logic req_wr = 1'h0, req_ready_data = 1'h0, req_idle_data = 1'h0;
	logic start_wr = 1'h0, cancel_wr = 1'h0, buf_wr = 1'h0, buf_rd = 1'h0;
	logic [31:0] start_data = 32'h0, cancel_data = 32'h0;
	logic [5:0] buf_wr_addr = 6'h00, buf_rd_addr = 6'h00;
	logic [7:0] buf_wr_data = 8'h00, buf_rd_data;
	logic buf_rd_valid, exec_done, exec_start, ready_request_bit;
	logic idle_request_bit, idle_flag, status_fault_flag;
	logic [6:0] cmd_length;
	logic [31:0] start_field, cancel_field;
	cbs_pkg::cbs_state_type state;
	int num_errors = 0;
	int compares = 0;

	always #2.5 clock = ~clock;

	cbs_ctrl cbs_ctrl_inst (.clock, .rstn, .req_wr, .req_ready_data,
		.req_idle_data, .start_wr, .start_data, .cancel_wr, .cancel_data,
		.buf_wr, .buf_wr_addr, .buf_wr_data, .buf_rd, .buf_rd_addr,
		.buf_rd_data, .buf_rd_valid, .exec_done, .exec_start, .cmd_length,
		.ready_request_bit, .idle_request_bit, .idle_flag, .status_fault_flag,
		.start_field, .cancel_field, .state);
	cbs_proc_model #(.DELAY(6)) cbs_proc_model_inst (.clock, .rstn,
		.exec_start, .exec_done);

	task give_verdict;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task check(string what, logic [31:0] exp, logic [31:0] seen);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One host access: 0 request (2 ready, 1 idle), 1 start, 2 cancel,
	// 3 buffer write, 4 buffer read.
	task drive(int k, logic [31:0] d, logic [5:0] a);
		@(posedge clock);
		case (k)
			0: {req_wr, req_ready_data, req_idle_data} <= {1'h1, d[1:0]};
			1: {start_wr, start_data} <= {1'h1, d};
			2: {cancel_wr, cancel_data} <= {1'h1, d};
			3: {buf_wr, buf_wr_addr, buf_wr_data} <= {1'h1, a, d[7:0]};
			default: {buf_rd, buf_rd_addr} <= {1'h1, a};
		endcase
		@(posedge clock);
		{req_wr, start_wr, cancel_wr, buf_wr, buf_rd} <= 5'h00;
		#1;
	endtask

	// Polls the state as host software would, but never without limit.
	// keep polling until the expected state shows
	task reach(cbs_pkg::cbs_state_type s);
		for (int n = 0; n < 40 && state !== s; n++)
			@(posedge clock) #1;
		check("state", s, state);
		if (state !== s)
			give_verdict();
	endtask

	task stay(cbs_pkg::cbs_state_type s);
		repeat (3) @(posedge clock);
		#1;
		check("state", s, state);
	endtask

	// only the values this design commits to are judged
	task flags(logic i, logic [31:0] st, logic [6:0] len);
		check("idle_flag", i, idle_flag);
		check("start_field", st, start_field);
		check("cancel_field", 32'h0, cancel_field);
		check("requests", 2'h0, {ready_request_bit, idle_request_bit});
		check("fault", 1'h0, status_fault_flag);
		check("cmd_length", len, cmd_length);
	endtask

	// The valid pulse stands only in the cycle after the strobe is taken,
	// which is where drive returns.
	task rd(logic [5:0] a, logic v, logic [7:0] d);
		drive(4, 0, a);
		check("buf_rd_valid", v, buf_rd_valid);
		if (v)
			check("buf_rd_data", d, buf_rd_data);
	endtask

	task s_idle;
		reach(cbs_pkg::CBS_IDLE);
		flags(1'h1, 0, 0);
		drive(0, 1, 0);
		drive(1, 1, 0);
		drive(2, 1, 0);
		drive(3, 8'h5A, 0);
		rd(0, 0, 0);
		stay(cbs_pkg::CBS_IDLE);
		flags(1'h1, 0, 0);
	endtask

	task s_ready;
		drive(0, 2, 0);
		reach(cbs_pkg::CBS_READY);
		flags(1'h0, 0, 0);
		drive(0, 2, 0);
		drive(1, 1, 0);
		drive(2, 1, 0);
		rd(0, 0, 0);
		stay(cbs_pkg::CBS_READY);
		flags(1'h0, 0, 0);
		drive(0, 1, 0);
		reach(cbs_pkg::CBS_IDLE);
		flags(1'h1, 0, 0);
	endtask

	task s_recv;
		drive(0, 2, 0);
		reach(cbs_pkg::CBS_READY);
		for (int i = 0; i < 3; i++)
			drive(3, 32'(i), 6'(i));
		reach(cbs_pkg::CBS_RECEPTION);
		drive(2, 1, 0);
		rd(0, 0, 0);
		drive(1, 0, 0);
		stay(cbs_pkg::CBS_RECEPTION);
		flags(1'h0, 0, 3);
		drive(3, 8'hA5, 0);
		stay(cbs_pkg::CBS_RECEPTION);
		flags(1'h0, 0, 1);
		drive(0, 2, 0);
		stay(cbs_pkg::CBS_READY);
		flags(1'h0, 0, 0);
	endtask

	task s_exec;
		drive(3, 8'h3C, 0);
		drive(1, 1, 0);
		reach(cbs_pkg::CBS_EXECUTION);
		check("exec_start", 1'h1, exec_start);
		flags(1'h0, 1, 1);
		drive(2, 1, 0);
		check("cancel_field", 32'h1, cancel_field);
		reach(cbs_pkg::CBS_COMPLETION);
		flags(1'h0, 0, 1);
		rd(0, 1, 8'h3C);
		drive(0, 1, 0);
		reach(cbs_pkg::CBS_IDLE);
		flags(1'h1, 0, 0);
	endtask

	initial begin
		repeat (16) @(posedge clock);
		rstn <= 1'h1;
		s_idle();
		s_ready();
		s_recv();
		s_exec();
		give_verdict();
	end
endmodule // test_command_buffer_state_ctrl
